// [shared/phy_page2_pkg.sv]
// Constants and carrier types for the alternate-page register bank of one PHY port.
// Assumes an APB master with 32-bit data; each management register sits at byte 4*index.
// Operation
// - Writing 0x0002 to register 31 selects the alternate page for upper addresses.
// - With alternate page selected, addresses 16 to 30 reach alternate-page registers.
// - Addresses 0 to 15 reach the standard registers whatever the page.
// - Writing zero to register 31 restores the standard upper register set.
// - Trim register holds gigabit, 100 Mb/s, 10 Mb/s codes driven to transmitter.
// - Bits 3:0 hold the low-energy 10 Mb/s code; resets 0000,0010,1011,1110.
// - EEE bit 15 enables low-energy 10 Mb/s mode; sticky, resets zero.
// - EEE bit 14 keeps indicators active in fiber unidirectional mode; sticky.
// - EEE bits 13:10 invert the active-low indicator outputs, serial one too.
// - EEE bits 8, 7, 6 read link up, gigabit EEE, 100 Mb/s EEE status.
// - EEE bit 5 with speed bits 10 allows gigabit link without forced role.
// - EEE bit 4 makes the packet generator send low-power idle, ignoring MAC.
// - With EEE bit 4 clear, transmitter passes idles received from the MAC.
// - EEE bit 3 stops 100 Mb/s transmit low-power idle toward the line while bit 4 is clear.
// - EEE bit 2 stops 100 Mb/s receive low-power idle toward the MAC.
// - EEE bit 1 stops gigabit transmit low-power idle toward the line while bit 4 is clear.
// - EEE bit 0 stops gigabit receive low-power idle toward the MAC.
package phy_page2_pkg;
  localparam logic [4:0] PAGE_REG_IDX = 5'h1F;
  localparam logic [4:0] CTRL0_IDX = 5'h00;
  localparam logic [4:0] trim_reg_addr = 5'h10;
  localparam logic [4:0] eee_ctrl_reg_addr = 5'h11;
  localparam logic [4:0] UPPER_FIRST_IDX = 5'h10;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_ALT2 = 16'h0002;
  localparam logic [15:0] TRIM_RESET = 16'h02BE;
  localparam logic [15:0] EEE_RESET = 16'h0000;
  localparam logic [15:0] EEE_RW_MASK = 16'hFC3F;
  localparam logic [15:0] CTRL0_RESET = 16'h1140;
  localparam logic [15:0] CTRL0_SW_RESET = 16'h8000;
  localparam int CTRL0_SPD_MSB = 6;
  localparam int CTRL0_SPD_LSB = 13;
  localparam logic [1:0] SPEED_GIG = 2'h2;
  localparam int EEE_LINK_BIT = 8;
  localparam int EEE_GIG_BIT = 7;
  localparam int EEE_FAST_BIT = 6;
  localparam int NUM_STD_REGS = 16;

  typedef struct packed {
    logic [3:0] gig;
    logic [3:0] fast;
    logic [3:0] ten;
    logic [3:0] ten_eee;
  } trim_t;

  typedef struct packed {
    logic ten_eee_en;
    logic ind_fiber_uni;
    logic [3:0] ind_invert;
    logic rsvd9;
    logic link_up;
    logic gig_eee;
    logic fast_eee;
    logic gig_force;
    logic force_lpi;
    logic fast_tx_lpi_inh;
    logic fast_rx_lpi_inh;
    logic gig_tx_lpi_inh;
    logic gig_rx_lpi_inh;
  } eee_ctrl_t;

  typedef struct packed {
    logic link_up;
    logic gig_eee;
    logic fast_eee;
  } phy_status_t;

  typedef struct packed {
    logic fast_mode;
    logic gig_mode;
    logic mac_tx_lpi;
    logic line_rx_lpi;
    logic [3:0] ind_raw;
  } datapath_in_t;

  typedef struct packed {
    logic line_tx_lpi;
    logic mac_rx_lpi;
    logic ignore_mac_data;
    logic gig_no_role_force;
    logic [3:0] indicator_outputs;
    logic ind_fiber_uni;
    logic ten_eee_en;
  } datapath_out_t;
endpackage

// [rtl/phy_page2_regs.sv]
// Management register bank with page select, transmit trim and EEE debug control.
// Assumes APB master on pclk; status and datapath inputs are synchronous to pclk.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module phy_page2_regs #(
  parameter int NUM_STD = phy_page2_pkg::NUM_STD_REGS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire phy_page2_pkg::phy_status_t status,
  input wire phy_page2_pkg::datapath_in_t dp_in,
  output phy_page2_pkg::datapath_out_t dp_out,
  output phy_page2_pkg::trim_t copper_tx_medium
);
  typedef struct packed {
    logic [15:0] page;
    logic [NUM_STD-1:0][15:0] std_regs;
    logic [15:0] std_upper_16;
    logic [15:0] std_upper_17;
    phy_page2_pkg::trim_t trim;
    phy_page2_pkg::eee_ctrl_t eee;
    logic [31:0] rdata;
    logic [4:0] sw_rst_pending;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic acc;
  logic wr;
  logic [4:0] idx;
  logic alt;
  logic upper;
  logic [15:0] wmask;
  logic [15:0] rd16;
  logic [15:0] eee_view;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign idx = paddr[6:2];
  assign alt = (s_q.page == phy_page2_pkg::PAGE_ALT2);
  assign upper = (idx >= phy_page2_pkg::UPPER_FIRST_IDX);
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = s_q.rdata;

  always_comb begin
    eee_view = s_q.eee;
    eee_view[phy_page2_pkg::EEE_LINK_BIT] = status.link_up;
    eee_view[phy_page2_pkg::EEE_GIG_BIT] = status.gig_eee;
    eee_view[phy_page2_pkg::EEE_FAST_BIT] = status.fast_eee;
    eee_view = eee_view & (phy_page2_pkg::EEE_RW_MASK |
                           (16'h0001 << phy_page2_pkg::EEE_LINK_BIT) |
                           (16'h0001 << phy_page2_pkg::EEE_GIG_BIT) |
                           (16'h0001 << phy_page2_pkg::EEE_FAST_BIT));
  end

  always_comb begin
    rd16 = 16'h0000;
    if (idx == phy_page2_pkg::PAGE_REG_IDX) begin
      rd16 = s_q.page;
    end else if (!upper) begin
      rd16 = s_q.std_regs[idx[3:0]];
    end else if (alt) begin
      if (idx == phy_page2_pkg::trim_reg_addr) begin
        rd16 = s_q.trim;
      end else if (idx == phy_page2_pkg::eee_ctrl_reg_addr) begin
        rd16 = eee_view;
      end
    end else if (idx == phy_page2_pkg::trim_reg_addr) begin
      rd16 = s_q.std_upper_16;
    end else if (idx == phy_page2_pkg::eee_ctrl_reg_addr) begin
      rd16 = s_q.std_upper_17;
    end
  end

  always_comb begin
    s_d = s_q;
    if (acc && !pwrite) begin
      s_d.rdata = {16'h0000, rd16};
    end
    if (s_q.sw_rst_pending[0]) begin
      // Port soft reset restores control register 0 only; sticky page-2 bits stay.
      s_d.std_regs[phy_page2_pkg::CTRL0_IDX] = phy_page2_pkg::CTRL0_RESET;
      s_d.sw_rst_pending = 5'h00;
    end
    if (wr) begin
      if (idx == phy_page2_pkg::PAGE_REG_IDX) begin
        s_d.page = merge(s_q.page, pwdata[15:0], wmask);
      end else if (!upper) begin
        s_d.std_regs[idx[3:0]] = merge(s_q.std_regs[idx[3:0]], pwdata[15:0], wmask);
        if (idx == phy_page2_pkg::CTRL0_IDX &&
            (pwdata[15:0] & wmask & phy_page2_pkg::CTRL0_SW_RESET) != 16'h0000) begin
          s_d.sw_rst_pending = 5'h01;
        end
      end else if (alt) begin
        if (idx == phy_page2_pkg::trim_reg_addr) begin
          s_d.trim = merge(s_q.trim, pwdata[15:0], wmask);
        end else if (idx == phy_page2_pkg::eee_ctrl_reg_addr) begin
          s_d.eee = merge(s_q.eee, pwdata[15:0],
                          wmask & phy_page2_pkg::EEE_RW_MASK);
        end
      end else if (idx == phy_page2_pkg::trim_reg_addr) begin
        s_d.std_upper_16 = merge(s_q.std_upper_16, pwdata[15:0], wmask);
      end else if (idx == phy_page2_pkg::eee_ctrl_reg_addr) begin
        s_d.std_upper_17 = merge(s_q.std_upper_17, pwdata[15:0], wmask);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.page <= phy_page2_pkg::PAGE_MAIN;
      s_q.std_regs[phy_page2_pkg::CTRL0_IDX] <= phy_page2_pkg::CTRL0_RESET;
      s_q.trim <= phy_page2_pkg::TRIM_RESET;
      s_q.eee <= phy_page2_pkg::EEE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Datapath effects are combinational so the LPI paths add no latency.
  always_comb begin
    logic [1:0] spd;
    spd = {s_q.std_regs[phy_page2_pkg::CTRL0_IDX][phy_page2_pkg::CTRL0_SPD_MSB],
           s_q.std_regs[phy_page2_pkg::CTRL0_IDX][phy_page2_pkg::CTRL0_SPD_LSB]};
    dp_out.gig_no_role_force = s_q.eee.gig_force && (spd == phy_page2_pkg::SPEED_GIG);
    dp_out.ignore_mac_data = s_q.eee.force_lpi;
    if (s_q.eee.force_lpi) begin
      dp_out.line_tx_lpi = 1'b1;
    end else begin
      dp_out.line_tx_lpi = dp_in.mac_tx_lpi
        && !(dp_in.fast_mode && s_q.eee.fast_tx_lpi_inh)
        && !(dp_in.gig_mode && s_q.eee.gig_tx_lpi_inh);
    end
    dp_out.mac_rx_lpi = dp_in.line_rx_lpi
      && !(dp_in.fast_mode && s_q.eee.fast_rx_lpi_inh)
      && !(dp_in.gig_mode && s_q.eee.gig_rx_lpi_inh);
    dp_out.indicator_outputs = ~dp_in.ind_raw ^ s_q.eee.ind_invert;
    dp_out.ind_fiber_uni = s_q.eee.ind_fiber_uni;
    dp_out.ten_eee_en = s_q.eee.ten_eee_en;
  end

  assign copper_tx_medium = s_q.trim;
endmodule

// [sim/phy_page2_regs_chk.sv]
// Port-level assertions for the alternate-page register bank.
// Assumes it is bound to phy_page2_regs and sees only its ports.
`timescale 1ns/1ps
module phy_page2_regs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire phy_page2_pkg::datapath_in_t dp_in,
  input wire phy_page2_pkg::datapath_out_t dp_out,
  input wire phy_page2_pkg::trim_t copper_tx_medium
);
  logic wr_q;
  logic rd_q;
  logic [15:0] pw_q;
  logic alt_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      pw_q <= 16'h0000;
      alt_q <= 1'b0;
    end else begin
      // Page is tracked from writes with both low byte strobes set only, so the trim check stays exact.
      if (psel && penable && pready && pwrite && paddr[6:2] == 5'h1F && pstrb[1:0] == 2'h3) begin
        alt_q <= (pwdata[15:0] == 16'h0002);
      end
      wr_q <= psel && penable && pready && pwrite;
      rd_q <= psel && penable && pready && !pwrite;
      pw_q <= pwdata[15:0];
    end
  end
  sequence s_trim_wr;
    psel && penable && pready && pwrite && paddr[6:2] == 5'h10 && alt_q && pstrb[1:0] == 2'h3;
  endsequence
  a_prdata_hold: assert property ($changed(prdata) |-> rd_q)
    else $error("read data moved without a read");
  a_trim_load: assert property (s_trim_wr |=> copper_tx_medium == pw_q)
    else $error("trim write stored a wrong value");
  a_trim_cause: assert property ($changed(copper_tx_medium) |-> wr_q)
    else $error("trim changed without a write");
  a_ten_cause: assert property ($changed(dp_out.ten_eee_en) |-> wr_q)
    else $error("low-energy enable changed without a write");
  a_ind_cause: assert property ($changed(dp_out.indicator_outputs) && $stable(dp_in.ind_raw) |-> wr_q)
    else $error("indicator polarity changed without a write");
  a_force_line: assert property (dp_out.ignore_mac_data |-> dp_out.line_tx_lpi)
    else $error("forced idle not sent on line");
  a_idle_pass: assert property (!dp_out.ignore_mac_data && !dp_in.mac_tx_lpi |-> !dp_out.line_tx_lpi)
    else $error("line idle without a cause");
  a_rx_source: assert property (!dp_in.line_rx_lpi |-> !dp_out.mac_rx_lpi)
    else $error("receive idle without a cause");
endmodule

// [sim/phy_ext_page2_tx_eee_ctrl_tb.sv]
// Self-checking bench for the alternate-page register bank, driven over APB.
// Assumes the package is compiled first and the checker file is compiled before it.
`timescale 1ns/1ps
module phy_ext_page2_tx_eee_ctrl_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  phy_page2_pkg::phy_status_t status = 3'h0;
  phy_page2_pkg::datapath_in_t dp_in = 8'h00;
  phy_page2_pkg::datapath_out_t dp_out;
  phy_page2_pkg::trim_t copper_tx_medium;
  logic [15:0] exp_q[$];
  logic [15:0] tv;
  logic rd_pend = 1'b0;
  logic [31:0] rnd = 32'h00015380;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  always #50 pclk = ~pclk;
  phy_page2_regs u_phy_page2_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .status(status), .dp_in(dp_in),
    .dp_out(dp_out), .copper_tx_medium(copper_tx_medium));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string nm);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Reads note their expected word; the watcher compares once prdata has loaded.
  task automatic apb(input logic w, input logic [4:0] i, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {5'h00, i, 2'b00};
    pwdata <= {16'h0000, d};
    if (!w) exp_q.push_back(d);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      final_report();
    end
    if (rd_pend) chk(prdata[15:0], exp_q.pop_front(), "prdata");
    if (rd_pend) chk(prdata[31:16], 16'h0000, "prdata_high");
    if (rd_pend) chk({15'h0000, pslverr}, 16'h0000, "pslverr");
    rd_pend <= psel && penable && pready && !pwrite;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(copper_tx_medium, 16'h02BE, "trim_reset");
    apb(1'b0, 5'h00, 16'h1140);
    apb(1'b1, 5'h10, 16'h1234);
    apb(1'b1, 5'h1F, 16'h0002);
    apb(1'b0, 5'h10, 16'h02BE);
    apb(1'b0, 5'h11, 16'h0000);
    rnd = xs(rnd);
    tv = rnd[15:0];
    apb(1'b1, 5'h10, tv);
    apb(1'b0, 5'h10, tv);
    chk(copper_tx_medium, tv, "trim_out");
    status <= 3'b101;
    dp_in <= {4'h7, rnd[19:16]};
    apb(1'b1, 5'h11, 16'hFFFF);
    apb(1'b0, 5'h11, 16'hFD7F);
    chk(16'(dp_out), {6'h00, 4'hB, dp_in.ind_raw, 2'b11}, "dp_all");
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      dp_in <= {i >= 2, i < 2, 2'b11, rnd[3:0]};
      apb(1'b1, 5'h11, 16'(1 << i));
      chk(16'(dp_out), {6'h00, i != 1 && i != 3, i != 0 && i != 2, 2'b00, ~rnd[3:0], 2'b00},
        "dp_inhibit");
    end
    apb(1'b1, 5'h11, 16'h0030);
    apb(1'b1, 5'h00, 16'h8000);
    apb(1'b0, 5'h00, 16'h1140);
    apb(1'b0, 5'h11, 16'h0170);
    apb(1'b0, 5'h14, 16'h0000);
    apb(1'b1, 5'h1F, 16'h0000);
    apb(1'b0, 5'h10, 16'h1234);
    chk(copper_tx_medium, tv, "trim_kept");
    apb(1'b1, 5'h1F, 16'h0002);
    apb(1'b1, 5'h11, 16'h0000);
    apb(1'b0, 5'h11, 16'h0140);
    repeat (3) @(posedge pclk);
    final_report();
  end
endmodule
bind phy_page2_regs phy_page2_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready), .dp_in(dp_in), .dp_out(dp_out), .copper_tx_medium(copper_tx_medium));
